// ===== test/host_model.sv
// Host model: drives both enable strobes.
// Assumes bench requests change at falling edges.
`default_nettype none
module host_model
(
    input  wire logic clock,
    input  wire logic mainReq,
    input  wire logic camReq,
    output var  logic main_enable_strobe = 1'b0,
    output var  logic cam_enable_strobe = 1'b0
);
    timeunit 1ns / 1ns;
    always @(negedge clock) {main_enable_strobe, cam_enable_strobe} <= {mainReq, camReq};
endmodule // host_model
`default_nettype wire

// ===== test/pump_chk.sv
// Checker on the pump mode control ports.
// Assumes one clock and bind into the design top.
`default_nettype none
module pump_chk
(
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       cam_enable_strobe,
    input wire logic       main_enable_strobe,
    input wire logic       dropout,
    input wire logic       overTemp,
    input wire logic       outAtOrBelowSupply,
    input wire logic [1:0] pumpMode,
    input wire logic       shutdown,
    input wire logic       passSwitchOn,
    input wire logic       sourcesOn,
    input wire logic       phaseA,
    input wire logic       phaseB
);
    timeunit 1ns / 1ns;
    logic [15:0] runQ;
    always_ff @(posedge clock) runQ <= dropout ? runQ + {15'h0, runQ != 16'hFFFF} : 16'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_dead; !phaseA && !phaseB; endsequence
    sequence s_off; !sourcesOn && !passSwitchOn && pumpMode == 2'h0; endsequence
    property p_off; shutdown [*2] |-> s_off; endproperty
    a_off: assert property (p_off) else $error("shutdown not quiet");
    property p_exit; main_enable_strobe || cam_enable_strobe |=> !shutdown; endproperty
    a_exit: assert property (p_exit) else $error("shutdown held");
    property p_heat; overTemp |=> !sourcesOn ##1 s_dead; endproperty
    a_heat: assert property (p_heat) else $error("hot but running");
    property p_cam; $fell(cam_enable_strobe) |-> ##3 pumpMode == 2'h0; endproperty
    a_cam: assert property (p_cam) else $error("mode kept");
    property p_step; $changed(pumpMode) |-> pumpMode == 2'h0 || pumpMode == $past(pumpMode) + 2'h1 && pumpMode != 2'h3;
    endproperty
    a_step: assert property (p_step) else $error("bad mode step");
    property p_wait; pumpMode > $past(pumpMode) |-> $past(runQ) > 16'h1F36; endproperty
    a_wait: assert property (p_wait) else $error("step too early");
    property p_pass; $rose(passSwitchOn) |-> $past(outAtOrBelowSupply) && pumpMode == 2'h0; endproperty
    a_pass: assert property (p_pass) else $error("pass closed early");
    property p_dead; $fell(phaseA) || $fell(phaseB) |-> s_dead; endproperty
    a_dead: assert property (p_dead) else $error("phase overlap");
endmodule // pump_chk
bind charge_pump_mode_control pump_chk chk (.clock(clock), .nrst(nrst), .cam_enable_strobe(cam_enable_strobe),
    .main_enable_strobe(main_enable_strobe), .dropout(dropout), .overTemp(overTemp), .pumpMode(pumpMode),
    .outAtOrBelowSupply(outAtOrBelowSupply), .shutdown(shutdown), .passSwitchOn(passSwitchOn),
    .sourcesOn(sourcesOn), .phaseA(phaseA), .phaseB(phaseB));
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the pump mode control.
// Assumes the host model drives the strobes.
`default_nettype none
`include "pump_ctrl_consts.vh"
module tb;
    timeunit 1ns / 1ns;
    logic clock = 1'b0, nrst = 1'b0, mainReq = 1'b0, camReq = 1'b0, mainS, camS, clkEn = 1'b1;
    logic dropout = 1'b0, overTemp = 1'b0, outOk = 1'b1, shutdown, weakLinkOn, passSwitchOn, sourcesOn, phA, phB;
    logic [1:0] pumpMode;
    logic [7:0] pumpStrength;
    int err_count = 0, tests_run = 0, seed = 32'hBD6E;
    host_model host (.clock(clock), .mainReq(mainReq), .camReq(camReq), .main_enable_strobe(mainS),
        .cam_enable_strobe(camS));
    charge_pump_mode_control dut (.clock(clock), .nrst(nrst), .clkEn(clkEn), .main_enable_strobe(mainS),
        .cam_enable_strobe(camS), .dropout(dropout), .overTemp(overTemp), .outAtOrBelowSupply(outOk),
        .pumpMode(pumpMode), .shutdown(shutdown), .weakLinkOn(weakLinkOn), .passSwitchOn(passSwitchOn),
        .sourcesOn(sourcesOn), .pumpStrength(pumpStrength), .phaseA(phA), .phaseB(phB));
    initial forever #25 clock = ~clock;
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        err_count += int'(seen !== exp);
        if (seen !== exp) $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
    endtask
    function automatic logic [1:0] nextMode(input logic [1:0] m);
        return (m == `MODE_2X) ? `MODE_2X : m + 2'h1;
    endfunction
    task automatic step(input int n);
        logic [1:0] was;
        was = pumpMode;
        dropout <= 1'b1;
        cyc(`STEP_DELAY_CYC - 5);
        chk(pumpMode, was);
        cyc(10);
        chk(pumpMode, nextMode(was));
        dropout <= 1'b0;
        cyc(n);
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        cyc(2);
        chk(weakLinkOn, 1'b1);
        {nrst, mainReq, camReq} <= 3'h7;
        cyc(4);
        chk(sourcesOn, 1'b1);
        dropout <= 1'b1;
        cyc(100 + ($random(seed) & 32'hFFF));
        dropout <= 1'b0;
        cyc(1);
        step(`RAMP_CYC + 10);
        chk(pumpStrength, `STR_MAX);
        {clkEn, dropout} <= 2'h1;
        cyc(`STEP_DELAY_CYC + 10);
        chk(pumpMode, `MODE_1P5X);
        {clkEn, dropout} <= 2'h2;
        cyc(1);
        step(5);
        step(5);
        overTemp <= 1'b1;
        cyc(3);
        chk(sourcesOn, 1'b0);
        overTemp <= 1'b0;
        cyc(3);
        chk(sourcesOn, 1'b1);
        {outOk, camReq} <= 2'h0;
        cyc(20);
        chk(pumpMode, `MODE_1X);
        chk(passSwitchOn, 1'b0);
        outOk <= 1'b1;
        cyc(3);
        chk(passSwitchOn, 1'b1);
        mainReq <= 1'b0;
        cyc(`SHDN_QUAL_CYC - 2);
        chk(shutdown, 1'b0);
        cyc(5);
        chk({weakLinkOn, shutdown, phA | phB}, 8'h6);
        wrap_up();
    end
    initial
    begin
        cyc(60000);
        err_count++;
        wrap_up();
    end
endmodule // tb
`default_nettype wire

// ===== verilog/charge_pump_mode_control.v
// Mode control for an LED charge pump: shutdown qualification, dropout
// driven mode stepping, thermal halt, soft-start and return to pass-through.
// Assumes strobes, dropout, thermal and comparator inputs are synchronous.
`default_nettype none
`include "pump_ctrl_consts.vh"

// Summary of operation
// - Both strobes low 150 us: shutdown
// - Shutdown: all off, weak supply link only
// - Overtemperature halts sources and pump until cool
// - Held dropout advances mode one step per delay period, up to 2x
// - Wait 0.4 ms before applying step
// - Shutdown or camera falling edge: 1x
// - After a camera falling edge, pass switches closed only when output decayed
// - Pump switches clocked at about 833 kHz (24-cycle period)
// - Non-overlapping phases, one-cycle (50 ns) dead time
// - Boost entry ramps strength over 150 us
module charge_pump_mode_control
(
    input  wire                 clock,
    input  wire                 nrst,
    input  wire                 clkEn,
    input  wire                 main_enable_strobe,
    input  wire                 cam_enable_strobe,
    input  wire                 dropout,
    input  wire                 overTemp,
    input  wire                 outAtOrBelowSupply,
    output reg  [1:0]           pumpMode,
    output reg                  shutdown,
    output reg                  weakLinkOn,
    output reg                  passSwitchOn,
    output reg                  sourcesOn,
    output reg  [`STR_W-1:0]    pumpStrength,
    output wire                 phaseA,
    output wire                 phaseB
);
    reg [`CNT_W-1:0] shdnCnt_q;
    reg [`CNT_W-1:0] stepCnt_q;
    reg [`CNT_W-1:0] rampCnt_q;
    reg              camPrev_q;
    reg              decay_q;
    reg [1:0]        mode_q;

    wire bothLow  = !main_enable_strobe && !cam_enable_strobe;
    wire camFall  = camPrev_q && !cam_enable_strobe;
    wire shdnHit  = bothLow && (shdnCnt_q == `SHDN_QUAL_CYC - 1);
    wire active   = !shutdown && !overTemp;
    wire canStep  = (mode_q != `MODE_2X);
    wire stepNow  = active && dropout && canStep && !camFall &&
                    (stepCnt_q == `STEP_DELAY_CYC - 1);
    wire boosting = (mode_q != `MODE_1X);
    // Ramp position scaled to full strength; only the low bits are kept
    wire [31:0] rampScaled = (rampCnt_q * `STR_MAX) / (`RAMP_CYC - 1);

    function [1:0] nextMode;
        input [1:0] m;
        begin
            case (m)
                `MODE_1X:   nextMode = `MODE_1P5X;
                `MODE_1P5X: nextMode = `MODE_2X;
                default:    nextMode = `MODE_2X;
            endcase
        end
    endfunction

    always @(posedge clock)
    begin
        if (!nrst)
        begin
            shdnCnt_q    <= {`CNT_W{1'b0}};
            stepCnt_q    <= {`CNT_W{1'b0}};
            rampCnt_q    <= {`CNT_W{1'b0}};
            camPrev_q    <= 1'b0;
            decay_q      <= 1'b0;
            mode_q       <= `MODE_1X;
            shutdown     <= 1'b1;
            weakLinkOn   <= 1'b1;
            passSwitchOn <= 1'b0;
            sourcesOn    <= 1'b0;
            pumpMode     <= `MODE_1X;
            pumpStrength <= {`STR_W{1'b0}};
        end
        else if (clkEn)
        begin
            camPrev_q <= cam_enable_strobe;

            // Shutdown qualification
            if (!bothLow)
            begin
                shdnCnt_q <= {`CNT_W{1'b0}};
                shutdown  <= 1'b0;
            end
            else if (shdnHit)
                shutdown <= 1'b1;
            else if (!shutdown)
                shdnCnt_q <= shdnCnt_q + 1'b1;

            // Dropout delay counter restarts whenever dropout clears
            if (!(active && dropout && canStep) || stepNow || camFall)
                stepCnt_q <= {`CNT_W{1'b0}};
            else
                stepCnt_q <= stepCnt_q + 1'b1;

            // Mode register
            if (shdnHit || camFall)
            begin
                mode_q  <= `MODE_1X;
                decay_q <= boosting;
            end
            else if (stepNow)
            begin
                mode_q    <= nextMode(mode_q);
                rampCnt_q <= {`CNT_W{1'b0}};
            end
            else
            begin
                if (decay_q && outAtOrBelowSupply)
                    decay_q <= 1'b0;
                if (rampCnt_q != `RAMP_CYC - 1)
                    rampCnt_q <= rampCnt_q + 1'b1;
            end

            // Outputs
            pumpMode     <= mode_q;
            weakLinkOn   <= shutdown;
            sourcesOn    <= active;
            passSwitchOn <= active && (mode_q == `MODE_1X) &&
                            !decay_q && !(stepNow || camFall);
            // Linear ramp of available pump current after boost entry
            if (active && boosting)
                pumpStrength <= rampScaled[`STR_W-1:0];
            else
                pumpStrength <= {`STR_W{1'b0}};
        end
    end

    pump_phase_gen phases
    (
        .clock  (clock),
        .nrst   (nrst),
        .clkEn  (clkEn),
        .run    (active && boosting),
        .phaseA (phaseA),
        .phaseB (phaseB)
    );
endmodule // charge_pump_mode_control
`default_nettype wire

// ===== verilog/pump_ctrl_consts.vh
// Timing and encoding constants for the charge pump mode control.
// Assumes a 20 MHz system clock; all counts derive from it.
`ifndef PUMP_CTRL_CONSTS_VH
`define PUMP_CTRL_CONSTS_VH

`define CLK_HZ              20000000
// Whole cycles per microsecond; keeps the long counts inside 32-bit arithmetic
`define CLK_MHZ             20
// Shutdown qualification time, microseconds
`define SHDN_QUAL_US        150
`define SHDN_QUAL_CYC       (`SHDN_QUAL_US * `CLK_MHZ)
// Dropout to mode change delay, microseconds (0.4 ms)
`define STEP_DELAY_US       400
`define STEP_DELAY_CYC      (`STEP_DELAY_US * `CLK_MHZ)
// Soft-start ramp, microseconds
`define RAMP_US             150
`define RAMP_CYC            (`RAMP_US * `CLK_MHZ)
// Pump oscillator, Hz; half period in cycles (longest time rounds down)
`define OSC_HZ              800000
`define OSC_HALF_CYC        (`CLK_HZ / (2 * `OSC_HZ))
// Dead time, nanoseconds (least time, round up, at least one cycle)
`define DEAD_NS             35
`define DEAD_CYC            ((`DEAD_NS * (`CLK_HZ / 1000000) + 999) / 1000)

`define CNT_W               14
`define PH_W                5
`define STR_W               8
`define STR_MAX             8'hFF

// Pump modes
`define MODE_1X             2'h0
`define MODE_1P5X           2'h1
`define MODE_2X             2'h2

`endif

// ===== verilog/pump_phase_gen.v
// Two-phase non-overlapping clock generator for the pump switches.
// Assumes the caller holds run low whenever the pump must not switch.
`default_nettype none
`include "pump_ctrl_consts.vh"

module pump_phase_gen
(
    input  wire clock,
    input  wire nrst,
    input  wire clkEn,
    input  wire run,
    output reg  phaseA,
    output reg  phaseB
);
    reg [`PH_W-1:0] cnt_q;
    reg             half_q;

    always @(posedge clock)
    begin
        if (!nrst || (clkEn && !run))
        begin
            cnt_q  <= {`PH_W{1'b0}};
            half_q <= 1'b0;
            phaseA <= 1'b0;
            phaseB <= 1'b0;
        end
        else if (clkEn)
        begin
            if (cnt_q == `OSC_HALF_CYC - 1)
            begin
                cnt_q  <= {`PH_W{1'b0}};
                half_q <= ~half_q;
            end
            else
                cnt_q <= cnt_q + 1'b1;
            // Both phases off during the dead time at the start of each half
            phaseA <= !half_q && (cnt_q >= `DEAD_CYC);
            phaseB <=  half_q && (cnt_q >= `DEAD_CYC);
        end
    end
endmodule // pump_phase_gen
`default_nettype wire
